//--- core/ccd_seq_cfg.svh
// named counts and timing figures for the ccd line readout sequencer
// assumes a single 25 MHz reference clock drives all sequencing logic
`ifndef CCD_SEQ_CFG_SVH
`define CCD_SEQ_CFG_SVH

// sensor geometry
`define ROWS_PER_FRAME 11'h3F2
`define ACTIVE_ELEMENTS 11'h40C
`define DUMMY_ELEMENTS 11'h009
`define SERIAL_ELEMENTS (`ACTIVE_ELEMENTS + `DUMMY_ELEMENTS)

// binning limits and defaults
`define VBIN_MAX 3'h4
`define HBIN_MAX 3'h4
`define BIN_ONE 3'h1

// clock rates in MHz
`define CLK_MHZ 25
`define SHIFT_FMAX_MHZ 40
`define XFER_FMAX_MHZ 10

// least half period in clock cycles, rounded up
`define SHIFT_HALF_CYC ((`CLK_MHZ + 2 * `SHIFT_FMAX_MHZ - 1) / (2 * `SHIFT_FMAX_MHZ))
`define GATE_HALF_CYC ((`CLK_MHZ + 2 * `XFER_FMAX_MHZ - 1) / (2 * `XFER_FMAX_MHZ))

// phase timer width
`define TMR_W 4

`endif

//--- core/ccd_seq_pkg.sv
// types shared by the ccd readout sequencer, its checker, the sensor model and the bench
// assumes ccd_seq_cfg.svh supplies the numeric constants
`default_nettype none

package ccd_seq_pkg;

   typedef enum logic [2:0] {
      IDLE = 3'h0,
      ROW_HI = 3'h1,
      ROW_LO = 3'h2,
      PIX_HI = 3'h3,
      PIX_LO = 3'h4,
      PIX_SENSE = 3'h5,
      PIX_RST = 3'h6,
      DONE = 3'h7
   } seq_state_e;

   typedef struct packed {
      logic [10:0] skipRows;
      logic [2:0] vBin;
      logic [2:0] hBin;
   } seq_cfg_s;

   typedef struct packed {
      logic storageGate;
      logic row_transfer_gate;
      logic serial_shift_gate;
      logic nodeResetGate;
   } gate_pins_s;

   typedef struct packed {
      logic [10:0] row;
      logic [10:0] col;
   } pix_tag_s;

endpackage

`default_nettype wire

//--- core/phase_timer.sv
// down counter timing one gate phase of the readout sequence
// assumes load comes from logic on ref_clk; loadValue is at least one
`default_nettype none
`include "ccd_seq_cfg.svh"

module phase_timer (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // control
   input wire logic load,
   input wire logic [`TMR_W-1:0] loadValue,
   // status
   output logic expired
);

   logic [`TMR_W-1:0] count_reg;
   logic [`TMR_W-1:0] count_next;

   assign expired = (count_reg == {`TMR_W{1'b0}});
   assign count_next = load ? (loadValue - {{(`TMR_W-1){1'b0}}, 1'b1}) :
                       (expired ? count_reg : (count_reg - {{(`TMR_W-1){1'b0}}, 1'b1}));

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         count_reg <= {`TMR_W{1'b0}};
      end else begin
         count_reg <= count_next;
      end
   end

endmodule

`default_nettype wire

//--- core/ccd_line_readout_sequencer.sv
// timing generator driving the storage, row-transfer, serial shift and node reset gates
// assumes gate drivers buffer these logic levels and a same-clock user issues start
//
// What this block does
// - serial shift gate never toggles faster than 40 MHz.
// - partial line dump: storage row transfer together with a row-transfer gate pulse.
// - vertical binning stacks several row transfers before shifting the line out.
// - number of stacked rows is clamped so the serial well never overflows.
// - horizontal binning withholds node resets between selected serial shifts.
// - node reset follows each sensed pixel unless horizontal binning is active.
// - each line takes 1036 active plus 9 dummy serial shifts.
// - a full frame sequences 1010 storage rows, one row at a time.
`default_nettype none
`include "ccd_seq_cfg.svh"

module ccd_line_readout_sequencer
   import ccd_seq_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // user command
   input wire logic start,
   input wire seq_cfg_s cfg,
   output logic busy,
   // user results
   output logic sampleStrobe,
   output pix_tag_s pixTag,
   output logic frameDone,
   // sensor gate pins
   output gate_pins_s gates
);

   seq_state_e state_reg;
   seq_state_e state_next;
   seq_cfg_s cfg_reg;
   logic [10:0] rowCnt_reg;
   logic [10:0] rowCnt_next;
   logic [10:0] dumpLeft_reg;
   logic [10:0] dumpLeft_next;
   logic [2:0] stackCnt_reg;
   logic [2:0] stackCnt_next;
   logic [10:0] colCnt_reg;
   logic [10:0] colCnt_next;
   logic [2:0] hCnt_reg;
   logic [2:0] hCnt_next;
   gate_pins_s gates_reg;
   gate_pins_s gates_next;
   logic sample_reg;
   logic done_reg;
   pix_tag_s tag_reg;

   // timer control
   logic tmrExpired;
   logic tmrLoad;
   logic [`TMR_W-1:0] tmrValue;

   phase_timer u_timer (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .load(tmrLoad),
      .loadValue(tmrValue),
      .expired(tmrExpired)
   );

   // effective bin factors; zero means no binning
   wire [2:0] vBinEff;
   wire [2:0] hBinEff;
   assign vBinEff = (cfg_reg.vBin == 3'h0) ? `BIN_ONE :
                    ((cfg_reg.vBin > `VBIN_MAX) ? `VBIN_MAX : cfg_reg.vBin);
   assign hBinEff = (cfg_reg.hBin == 3'h0) ? `BIN_ONE :
                    ((cfg_reg.hBin > `HBIN_MAX) ? `HBIN_MAX : cfg_reg.hBin);

   // decodes
   wire idle = (state_reg == IDLE);
   wire takeStart = idle & start;
   wire dumping = (dumpLeft_reg != 11'h000);
   wire lastRowHere = (rowCnt_reg == (`ROWS_PER_FRAME - 11'h001));
   wire allRowsDone = (rowCnt_reg == `ROWS_PER_FRAME);
   wire stackDone = (stackCnt_reg == (vBinEff - `BIN_ONE));
   wire lastCol = (colCnt_reg == (`SERIAL_ELEMENTS - 11'h001));
   wire resetDue = (hCnt_reg == (hBinEff - `BIN_ONE)) | lastCol;
   wire rowEnd = (state_reg == ROW_LO) & tmrExpired;
   wire senseEnd = (state_reg == PIX_SENSE) & tmrExpired;
   wire pixEnd = (senseEnd & ~resetDue) | ((state_reg == PIX_RST) & tmrExpired);
   wire lineGo = allRowsDone ? 1'b1 : 1'b0;
   seq_state_e afterLine;
   assign afterLine = lineGo ? DONE : ROW_HI;

   // sequencing
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         IDLE: begin
            if (start) begin
               state_next = ROW_HI;
            end
         end
         ROW_HI: begin
            if (tmrExpired) begin
               state_next = ROW_LO;
            end
         end
         ROW_LO: begin
            if (tmrExpired) begin
               if (dumping) begin
                  state_next = lastRowHere ? DONE : ROW_HI;
               end else if (stackDone | lastRowHere) begin
                  state_next = PIX_HI;
               end else begin
                  state_next = ROW_HI;
               end
            end
         end
         PIX_HI: begin
            if (tmrExpired) begin
               state_next = PIX_LO;
            end
         end
         PIX_LO: begin
            if (tmrExpired) begin
               state_next = PIX_SENSE;
            end
         end
         PIX_SENSE: begin
            if (tmrExpired) begin
               if (resetDue) begin
                  state_next = PIX_RST;
               end else begin
                  state_next = PIX_HI;
               end
            end
         end
         PIX_RST: begin
            if (tmrExpired) begin
               state_next = lastCol ? afterLine : PIX_HI;
            end
         end
         DONE: begin
            state_next = IDLE;
         end
      endcase
   end

   // every state change opens a new timed phase
   assign tmrLoad = (state_next != state_reg);
   wire rowPhase = (state_next == ROW_HI) | (state_next == ROW_LO);
   assign tmrValue = rowPhase ? `TMR_W'(`GATE_HALF_CYC) : `TMR_W'(`SHIFT_HALF_CYC);

   // counters
   assign rowCnt_next = takeStart ? 11'h000 :
                        (rowEnd ? (rowCnt_reg + 11'h001) : rowCnt_reg);
   assign dumpLeft_next = takeStart ? cfg.skipRows :
                          ((rowEnd & dumping) ? (dumpLeft_reg - 11'h001) : dumpLeft_reg);
   assign stackCnt_next = (takeStart | (rowEnd & (dumping | stackDone | lastRowHere))) ? 3'h0 :
                          (rowEnd ? (stackCnt_reg + 3'h1) : stackCnt_reg);
   assign colCnt_next = (takeStart | (pixEnd & lastCol)) ? 11'h000 :
                        (pixEnd ? (colCnt_reg + 11'h001) : colCnt_reg);
   assign hCnt_next = (takeStart | (pixEnd & resetDue)) ? 3'h0 :
                      (pixEnd ? (hCnt_reg + 3'h1) : hCnt_reg);

   // gate levels for the coming phase
   // the node is flushed during the row phase so a line never starts on stale charge
   wire nextRow = (state_next == ROW_HI);
   assign gates_next.storageGate = nextRow;
   assign gates_next.row_transfer_gate = nextRow & (takeStart ? (cfg.skipRows != 11'h000) :
                                         (rowEnd ? (dumpLeft_reg > 11'h001) : dumping));
   assign gates_next.serial_shift_gate = (state_next == PIX_HI);
   assign gates_next.nodeResetGate = (state_next == PIX_RST) | (state_next == ROW_LO);

   // single sample per reset, no reference sample needed
   wire sampleNext = senseEnd & resetDue;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= IDLE;
         cfg_reg <= '0;
      end else begin
         state_reg <= state_next;
         cfg_reg <= takeStart ? cfg : cfg_reg;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rowCnt_reg <= 11'h000;
         dumpLeft_reg <= 11'h000;
         stackCnt_reg <= 3'h0;
         colCnt_reg <= 11'h000;
         hCnt_reg <= 3'h0;
      end else begin
         rowCnt_reg <= rowCnt_next;
         dumpLeft_reg <= dumpLeft_next;
         stackCnt_reg <= stackCnt_next;
         colCnt_reg <= colCnt_next;
         hCnt_reg <= hCnt_next;
      end
   end

   // registered pins keep gate edges glitch free
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         gates_reg <= '0;
         sample_reg <= 1'b0;
         done_reg <= 1'b0;
         tag_reg <= '0;
      end else begin
         gates_reg <= gates_next;
         sample_reg <= sampleNext;
         done_reg <= (state_next == DONE) & (state_reg != DONE);
         tag_reg <= sampleNext ? {rowCnt_reg - 11'h001, colCnt_reg} : tag_reg;
      end
   end

   // outputs
   assign gates = gates_reg;
   assign sampleStrobe = sample_reg;
   assign pixTag = tag_reg;
   assign frameDone = done_reg;
   assign busy = ~idle;

endmodule

`default_nettype wire

//--- testbench/ccd_seq_assertions.sv
// port checker for the readout sequencer
// assumes bind onto ccd_line_readout_sequencer
`default_nettype none

module ccd_seq_checker
   import ccd_seq_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // command
   input wire logic start,
   input wire seq_cfg_s cfg,
   input wire logic busy,
   // results and gates
   input wire logic sampleStrobe,
   input wire pix_tag_s pixTag,
   input wire logic frameDone,
   input wire gate_pins_s gates
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence end_s;
      busy ##1 !busy;
   endsequence
   sequence row_low_s;
      !gates.serial_shift_gate [*2];
   endsequence
   a_shift_high_once: assert property ($rose(gates.serial_shift_gate) |=> !gates.serial_shift_gate)
      else $error("shift gate high too long");
   a_sample_has_reset: assert property (sampleStrobe |-> gates.nodeResetGate)
      else $error("sample without node reset");
   a_sample_after_shift: assert property (sampleStrobe |-> $past(gates.serial_shift_gate, 3)
      && !$past(gates.serial_shift_gate, 2))
      else $error("sample not three cycles after shift");
   a_dump_with_row: assert property (gates.row_transfer_gate |-> gates.storageGate)
      else $error("transfer gate without storage row");
   a_row_then_low: assert property ($fell(gates.storageGate) |-> row_low_s)
      else $error("shift inside row low phase");
   a_no_shift_row: assert property (gates.storageGate |-> !gates.serial_shift_gate)
      else $error("shift during row transfer");
   a_start_taken: assert property (start && !busy |=> busy && gates.storageGate)
      else $error("start not taken");
   a_done_ends: assert property (frameDone |-> end_s)
      else $error("frame end without busy drop");
endmodule

bind ccd_line_readout_sequencer ccd_seq_checker u_checker (.ref_clk(ref_clk), .nrst(nrst), .start(start),
   .cfg(cfg), .busy(busy), .sampleStrobe(sampleStrobe), .pixTag(pixTag), .frameDone(frameDone), .gates(gates));

`default_nettype wire

//--- testbench/ccd_sensor_model.sv
// behavioural sensor: serial register, stack and sense node
// assumes gate levels straight from the sequencer
`default_nettype none

module ccd_sensor_model
   import ccd_seq_pkg::*;
(
   // gates and bench control
   input wire gate_pins_s gates,
   input wire logic clearCounts,
   // observed charge movement
   output logic [10:0] rowsMoved,
   output logic [10:0] rowsDumped,
   output logic [2:0] maxStack,
   output logic [10:0] lineShifts,
   output logic [2:0] maxNode
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] stack;
   logic [2:0] node;
   always @(posedge clearCounts) begin
      {rowsMoved, rowsDumped, lineShifts} = 33'h0;
      {maxStack, maxNode, stack, node} = 12'h0;
   end
   always @(posedge gates.storageGate) begin
      if (gates.row_transfer_gate) begin
         rowsDumped = rowsDumped + 11'h1;
      end else begin
         rowsMoved = rowsMoved + 11'h1;
         stack = stack + 3'h1;
         if (stack > maxStack) maxStack = stack;
      end
   end
   // no clock of its own: charge moves on gate edges only
   always @(negedge gates.serial_shift_gate) begin
      if (stack != 3'h0) begin
         lineShifts = 11'h0;
         stack = 3'h0;
      end
      lineShifts = lineShifts + 11'h1;
      node = node + 3'h1;
      if (node > maxNode) maxNode = node;
   end
   always @(posedge gates.nodeResetGate) node = 3'h0;
endmodule

`default_nettype wire

//--- testbench/testbench.sv
// frame level bench for the readout sequencer
// assumes the sensor model and bound checker
`default_nettype none

module testbench
   import ccd_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic start = 1'b0;
   logic clearCounts = 1'b0;
   seq_cfg_s cfg = '0;
   logic busy, sampleStrobe, frameDone;
   pix_tag_s pixTag, lastTag;
   gate_pins_s gates;
   logic [10:0] rowsMoved, rowsDumped, lineShifts;
   logic [2:0] maxStack, maxNode;
   logic [21:0] samples, dones;
   int fail_count = 0;
   int check_count = 0;

   ccd_line_readout_sequencer u_ccd_line_readout_sequencer (.ref_clk(ref_clk), .nrst(nrst), .start(start),
      .cfg(cfg), .busy(busy), .sampleStrobe(sampleStrobe), .pixTag(pixTag), .frameDone(frameDone),
      .gates(gates));
   ccd_sensor_model u_sensor (.gates(gates), .clearCounts(clearCounts), .rowsMoved(rowsMoved),
      .rowsDumped(rowsDumped), .maxStack(maxStack), .lineShifts(lineShifts), .maxNode(maxNode));

   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (sampleStrobe === 1'b1) begin
         samples = samples + 22'h1;
         lastTag = pixTag;
      end
      if (frameDone === 1'b1) dones = dones + 22'h1;
   end

   task check(input logic [21:0] seen, input logic [21:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task stop_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // a second start mid-frame must be ignored
   task run_frame(input logic [10:0] skip, input logic [2:0] vb, input logic [2:0] hb);
      int n;
      @(negedge ref_clk);
      {clearCounts, start, samples, dones} = {2'h3, 44'h0};
      cfg = {skip, vb, hb};
      @(negedge ref_clk);
      {clearCounts, start} = 2'h0;
      for (n = 0; n < 20000 && dones == 22'h0; n++) begin
         @(negedge ref_clk);
         start = (n == 100);
      end
      if (dones == 22'h0) begin
         fail_count++;
         $display("mismatch at %0t: frame timeout", $time);
         stop_test();
      end
      repeat (3) @(negedge ref_clk);
      check(busy, 22'h0);
      check(dones, 22'h1);
      check(rowsMoved + rowsDumped, 22'h3F2);
   endtask

   task dump_all;
      run_frame(11'h3F2, 3'h1, 3'h1);
      check(samples, 22'h0);
      check(rowsDumped, 22'h3F2);
   endtask

   task one_line;
      run_frame(11'h3F1, 3'h0, 3'h1);
      check(samples, 22'h415);
      check(lineShifts, 22'h415);
      check(lastTag, {11'h3F1, 11'h414});
      check(maxNode, 22'h1);
   endtask

   task hbin_line;
      run_frame(11'h3F1, 3'h1, 3'h4);
      check(samples, 22'h106);
      check(maxNode, 22'h4);
      check(lastTag, {11'h3F1, 11'h414});
   endtask

   // reset in mid-frame must drop every gate and return to idle
   task reset_mid;
      @(negedge ref_clk);
      {clearCounts, start} = 2'h1;
      cfg = {11'h000, 3'h1, 3'h1};
      @(negedge ref_clk);
      start = 1'b0;
      repeat (50) @(negedge ref_clk);
      check({21'h0, busy}, 22'h1);
      nrst = 1'b0;
      @(negedge ref_clk);
      check({busy, sampleStrobe, frameDone, gates}, 22'h0);
      nrst = 1'b1;
      @(negedge ref_clk);
      check({busy, sampleStrobe, frameDone, gates}, 22'h0);
   endtask

   // over-range binning must clamp to four rows and four pixels
   task vbin_stack;
      run_frame(11'h3ED, 3'h7, 3'h7);
      check(maxStack, 22'h4);
      check(rowsMoved, 22'h5);
      check(samples, 22'h20C);
      check(lastTag.row, 22'h3F1);
      check(maxNode, 22'h4);
   endtask

   initial begin
      repeat (6) @(negedge ref_clk);
      nrst = 1'b1;
      dump_all();
      one_line();
      reset_mid();
      hbin_line();
      vbin_stack();
      stop_test();
   end
endmodule

`default_nettype wire
